// file: dv/bps_boot_sel_monitor.sv
/*
 checker for bps_boot_sel: commit, gating, clock source and go rules.
 assumes one sys_clk domain and srst synchronous active high.
*/
`timescale 1ns/10ps
module bps_boot_mon (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        go_cmd_i,
  input wire logic [2:0]  sel_if_q,
  input wire logic        committed_q,
  input wire logic [6:0]  port_clk_en_q,
  input wire logic [6:0]  port_irq_en_q,
  input wire logic        usb_force_dev_q,
  input wire logic [1:0]  sys_clk_src_q,
  input wire logic        pll_en_q,
  input wire logic [7:0]  pll_mult_q,
  input wire logic [7:0]  crystal_mhz_q,
  input wire logic [31:0] hs_periph_clk_en_q,
  input wire logic [1:0]  async_fmt_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_ss_pick; $changed(sel_if_q) && sel_if_q == 3'h4; endsequence
  sequence s_ss_lock; committed_q && port_clk_en_q == 7'h10; endsequence
  ss_commit_a: assert property (s_ss_pick |-> ##1 s_ss_lock)
    else $error("ss choice not committed next cycle");
  gate_clk_a: assert property (committed_q |-> port_clk_en_q == (7'h01 << sel_if_q))
    else $error("clock gates not limited to chosen port");
  gate_irq_a: assert property (committed_q |-> port_irq_en_q == (7'h01 << sel_if_q))
    else $error("irq gates not limited to chosen port");
  rc_kept_a: assert property (committed_q && sel_if_q inside {3'h1, 3'h2, 3'h3}
    |-> sys_clk_src_q == 2'h0)
    else $error("slow path left rc clock");
  rc_left_a: assert property ($rose(committed_q) && sel_if_q >= 3'h5
    |-> sys_clk_src_q == 2'h1 && pll_en_q)
    else $error("usb or net path still on rc clock");
  pll_setup_a: assert property (sys_clk_src_q == 2'h1 |-> pll_mult_q == 8'h3c / crystal_mhz_q
    && crystal_mhz_q >= 8'h04 && crystal_mhz_q <= 8'h1a)
    else $error("pll setting wrong for crystal");
  usb_dev_a: assert property (committed_q && sel_if_q == 3'h5 |-> usb_force_dev_q)
    else $error("usb not forced to device role");
  go_clear_a: assert property (committed_q && go_cmd_i
    |-> ##[1:3] hs_periph_clk_en_q == 32'h0)
    else $error("go did not clear peripheral enables");
  choice_hold_a: assert property (committed_q |=> committed_q && $stable(sel_if_q))
    else $error("committed choice changed");
  async_fmt_a: assert property (committed_q && sel_if_q == 3'h1
    |-> async_fmt_q == 2'h1)
    else $error("async frame format not set");
endmodule
bind bps_boot_sel bps_boot_mon i_mon (.sys_clk, .srst, .go_cmd_i, .sel_if_q, .committed_q,
  .port_clk_en_q, .port_irq_en_q, .usb_force_dev_q, .sys_clk_src_q, .pll_en_q,
  .pll_mult_q, .crystal_mhz_q, .hs_periph_clk_en_q, .async_fmt_q);

// file: dv/bps_host_model.sv
/*
 programming host: sync serial master (mode 0), two-wire address sender, async sender.
 assumes the bench calls its tasks just after a sys_clk rising edge.
*/
`timescale 1ns/10ps
module bps_host_model (
  input  wire logic sys_clk,
  input  wire logic miso,
  input  wire logic sda_w,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  output logic      scl,
  output logic      sda,
  output logic      ack_seen,
  output logic      txd
);
  localparam int H = 32; // half of scl period, under 400 kHz
  logic rel;
  initial begin
    sck = 0; cs_n = 1; mosi = 0; scl = 1; sda = 1; rel = 0; ack_seen = 0;
    txd = 1; // idle mark
  end
  always @(posedge sys_clk) if (rel && !sda_w) ack_seen <= 1;
  // 4-cycle halves keep sck near 3 MHz, under the 8 MHz ceiling
  task ss_xfer(input [7:0] d, output [7:0] q);
    integer i;
    begin
      cs_n <= 0;
      for (i = 7; i >= 0; i = i - 1) begin // msb first
        mosi <= d[i];
        repeat (4) @(posedge sys_clk);
        sck <= 1;
        repeat (4) @(posedge sys_clk);
        q[i] = miso;
        sck <= 0;
      end
      repeat (4) @(posedge sys_clk);
      cs_n <= 1;
      mosi <= 0; // pull-down once released
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task tw_addr(input [7:0] b);
    integer i;
    begin
      ack_seen <= 0;
      sda <= 0;
      repeat (H) @(posedge sys_clk);
      scl <= 0;
      for (i = 7; i >= 0; i = i - 1) begin
        sda <= b[i];
        repeat (H) @(posedge sys_clk);
        scl <= 1;
        repeat (H) @(posedge sys_clk);
        scl <= 0;
      end
      sda <= 1;
      rel <= 1;
      repeat (H) @(posedge sys_clk);
      scl <= 1;
      repeat (H) @(posedge sys_clk);
      scl <= 0;
      rel <= 0;
      sda <= 0;
      repeat (H) @(posedge sys_clk);
      scl <= 1;
      repeat (H) @(posedge sys_clk);
      sda <= 1;
      repeat (H) @(posedge sys_clk);
    end
  endtask
  // 57.6 kbaud frame: start, 8 data lsb first, even parity, stop
  task async_byte(input [7:0] b);
    integer i;
    logic [10:0] f;
    begin
      f = {1'b1, ^b, b, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        txd <= f[i];
        repeat (434) @(posedge sys_clk);
      end
    end
  endtask
endmodule

// file: dv/tb.sv
/*
 testbench for bps_boot_sel: sync serial, two-wire, async, usb and net boot paths.
 assumes the host model drives serial pins and crystal ticks come at 5 MHz.
*/
`timescale 1ns/10ps
module tb;
  logic sys_clk, srst, usb_cable_i, net_frame_i, crystal_tick_i, go_cmd_i, tick_on;
  logic [7:0] ss_tx_byte, rx;
  logic [2:0] tcnt;
  int fail_count, n_compared, i;
  wire sck, cs_n, mosi, scl, sda, ack_seen, tw3_ack_oe_n_q, ss_miso_q, committed_q;
  wire usb_force_dev_q, pll_en_q, crystal_bad_q, txd;
  wire [2:0] sel_if_q;
  wire [6:0] port_clk_en_q, port_irq_en_q;
  wire [1:0] sys_clk_src_q, async_fmt_q;
  wire [7:0] pll_mult_q, crystal_mhz_q, rx_byte_q;
  wire [31:0] hs_periph_clk_en_q;
  wire tw3_sda = sda & tw3_ack_oe_n_q; // open-drain wire
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tcnt <= (!tick_on || tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    crystal_tick_i <= tick_on && tcnt == 3'h4;
  end
  bps_host_model i_host (.sys_clk(sys_clk), .miso(ss_miso_q), .sda_w(tw3_sda), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .scl(scl), .sda(sda), .ack_seen(ack_seen), .txd(txd));
  bps_boot_sel i_dut (.sys_clk(sys_clk), .srst(srst), .async_rx_i(txd), .tw3_scl_i(scl),
    .tw3_sda_i(tw3_sda), .tw4_scl_i(1'b1), .tw4_sda_i(1'b1), .ss_sck_i(sck),
    .ss_cs_n_i(cs_n), .ss_mosi_i(mosi), .usb_cable_i(usb_cable_i),
    .net_frame_i(net_frame_i), .crystal_tick_i(crystal_tick_i), .go_cmd_i(go_cmd_i),
    .ss_tx_byte(ss_tx_byte), .tw3_ack_oe_n_q(tw3_ack_oe_n_q), .tw4_ack_oe_n_q(),
    .ss_miso_q(ss_miso_q), .sel_if_q(sel_if_q), .committed_q(committed_q),
    .rx_byte_valid_q(), .rx_byte_q(rx_byte_q), .port_clk_en_q(port_clk_en_q),
    .port_irq_en_q(port_irq_en_q), .usb_force_dev_q(usb_force_dev_q),
    .sys_clk_src_q(sys_clk_src_q), .pll_en_q(pll_en_q), .pll_mult_q(pll_mult_q),
    .crystal_mhz_q(crystal_mhz_q), .crystal_bad_q(crystal_bad_q),
    .hs_periph_clk_en_q(hs_periph_clk_en_q), .async_fmt_q(async_fmt_q));
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp) begin
        fail_count++;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      srst <= 1;
      usb_cable_i <= 0;
      net_frame_i <= 0;
      go_cmd_i <= 0;
      tick_on <= 0;
      repeat (12) @(posedge sys_clk);
      srst <= 0;
      @(posedge sys_clk);
    end
  endtask
  task wait_commit(input int lim);
    begin
      for (i = 0; i < lim && committed_q !== 1'b1; i++) @(posedge sys_clk);
      if (committed_q !== 1'b1) begin
        fail_count++;
        $display("BAD commit expected 1 seen %b", committed_q);
        test_done;
      end
    end
  endtask
  initial begin
    fail_count = 0;
    n_compared = 0;
    ss_tx_byte <= 8'h00;
    do_reset;
    chk("clk_en", 32'h7e, port_clk_en_q);
    chk("hs_en", 32'h1, hs_periph_clk_en_q);
    i_host.ss_xfer(8'ha5, rx);
    wait_commit(20);
    chk("sel", 32'h4, sel_if_q);
    chk("rx", 32'ha5, rx_byte_q);
    chk("irq_en", 32'h10, port_irq_en_q);
    ss_tx_byte <= 8'hc3;
    @(posedge sys_clk); // next byte loads while chip select is high or at the 8th rising sck edge
    i_host.ss_xfer(8'h3c, rx);
    chk("miso", 32'hc3, rx);
    chk("rx2", 32'h3c, rx_byte_q);
    go_cmd_i <= 1;
    @(posedge sys_clk);
    go_cmd_i <= 0;
    repeat (4) @(posedge sys_clk);
    chk("hs_go", 32'h0, hs_periph_clk_en_q);
    $display("ss test done");
    do_reset;
    i_host.tw_addr({7'h47, 1'b0});
    chk("bad_addr", 32'h0, committed_q);
    chk("bad_ack", 32'h0, ack_seen);
    i_host.tw_addr({7'h46, 1'b0});
    wait_commit(40);
    chk("tw_sel", 32'h2, sel_if_q);
    chk("tw_ack", 32'h1, ack_seen);
    chk("tw_src", 32'h0, sys_clk_src_q);
    chk("tw_en", 32'h4, port_clk_en_q);
    $display("two-wire test done");
    do_reset;
    i_host.async_byte(8'h7e);
    chk("async_bad", 32'h0, committed_q);
    i_host.async_byte(8'h7f);
    wait_commit(20);
    chk("as_sel", 32'h1, sel_if_q);
    chk("as_fmt", 32'h1, async_fmt_q);
    chk("as_src", 32'h0, sys_clk_src_q);
    chk("as_en", 32'h2, port_clk_en_q);
    $display("async test done");
    do_reset;
    tick_on <= 1; // 5 MHz board crystal
    usb_cable_i <= 1;
    wait_commit(30000);
    chk("usb_sel", 32'h5, sel_if_q);
    chk("mhz", 32'h5, crystal_mhz_q);
    chk("mult", 32'h0c, pll_mult_q);
    chk("src", 32'h1, sys_clk_src_q);
    chk("usb_dev", 32'h1, usb_force_dev_q);
    $display("usb test done");
    do_reset;
    net_frame_i <= 1;
    repeat (26000) @(posedge sys_clk);
    chk("no_xtal", 32'h1, crystal_bad_q);
    chk("no_pll", 32'h0, sys_clk_src_q);
    $display("net test done");
    test_done;
  end
endmodule

// file: hdl/bps_boot_sel.v
/*
 boot port selection: polls the candidate download ports, commits to the first
 showing valid activity, gates the rest and steers the system clock choice.
 assumes all pins synchronous to sys_clk (25 MHz, from the internal rc clock)
 and crystal_tick_i one pulse per external crystal cycle, already synchronised.
*/
// Contract
// - two-wire slaves use 7-bit address 0b1000110x, last bit write/read, filter on; code has no filter, inputs assumed pre-filtered
// - third two-wire port runs up to 400 kHz bus clock
// - fourth two-wire port runs up to 1 MHz bus clock
// - sync serial ports are full-duplex slaves, 8-bit frames, msb first
// - sync serial mode 0, hardware chip select, clock at most 8 MHz
// - usb path forces the on-the-go controller into device role
// - network and usb paths measure crystal against rc clock with timer
// - after measurement system clock goes to 60 MHz from pll on crystal; code uses integer 60/MHz multiplier, exact only when MHz divides 60
// - async serial and two-wire paths keep system clock on rc oscillator
// - network and usb paths use rc clock only during selection
// - jump to user code clears peripheral clock enable to zero
// - async serial ports use 8 data bits, even parity, one stop
`timescale 1ns/10ps
`include "bps_map.vh"

module bps_boot_sel (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        async_rx_i,
  input  wire        tw3_scl_i,
  input  wire        tw3_sda_i,
  input  wire        tw4_scl_i,
  input  wire        tw4_sda_i,
  input  wire        ss_sck_i,
  input  wire        ss_cs_n_i,
  input  wire        ss_mosi_i,
  input  wire        usb_cable_i,
  input  wire        net_frame_i,
  input  wire        crystal_tick_i,
  input  wire        go_cmd_i,
  input  wire [7:0]  ss_tx_byte,
  output reg         tw3_ack_oe_n_q,
  output reg         tw4_ack_oe_n_q,
  output reg         ss_miso_q,
  output reg  [2:0]  sel_if_q,
  output reg         committed_q,
  output reg  [2:0]  rx_byte_valid_q,
  output reg  [7:0]  rx_byte_q,
  output reg  [6:0]  port_clk_en_q,
  output reg  [6:0]  port_irq_en_q,
  output reg         usb_force_dev_q,
  output reg  [1:0]  sys_clk_src_q,
  output reg         pll_en_q,
  output reg  [7:0]  pll_mult_q,
  output reg  [7:0]  crystal_mhz_q,
  output reg         crystal_bad_q,
  output reg  [31:0] hs_periph_clk_en_q,
  output reg  [1:0]  async_fmt_q
);
  localparam ST_POLL = 3'h0;
  localparam ST_MEAS = 3'h1;
  localparam ST_LOCK = 3'h2;
  localparam ST_RUN  = 3'h3;
  localparam ST_FAIL = 3'h4;

  reg  [2:0]  st_q;
  reg  [15:0] win_q;
  reg  [15:0] xcnt_q;
  reg         rx_q;
  reg  [3:0]  abit_q;
  reg  [9:0]  ash_q;
  reg         abusy_q;
  reg  [11:0] adiv_q;
  reg         tw3_scl_q;
  reg         tw4_scl_q;
  reg         tw3_pend_q;
  reg         tw4_pend_q;

  wire        tw3_m;
  wire        tw3_rd;
  wire        tw4_m;
  wire        tw4_rd;
  wire [7:0]  ss_rx;
  wire        ss_v;
  wire        ss_miso_q_w;
  wire        polling = (st_q == ST_POLL);

  // one-hot port gate per interface code
  function [6:0] port_bit;
    input [2:0] code;
    begin
      port_bit = 7'h01 << code;
    end
  endfunction

  // crystal ticks in 1 ms window / 1000 gives MHz
  function [7:0] to_mhz;
    input [15:0] ticks;
    reg   [15:0] q;
    begin
      q      = (ticks + `BPS_TICKS_ROUND) / `BPS_TICKS_PER_MHZ;
      to_mhz = q[7:0];
    end
  endfunction

  // high-to-low step between two samples of a pin
  function fell;
    input prev_lvl;
    input cur_lvl;
    begin
      fell = prev_lvl & ~cur_lvl;
    end
  endfunction

  // no input filter; address match per port
  bps_tw_addr u_tw3 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .enable  (polling | (sel_if_q == `BPS_IF_TW3)),
    .scl_i   (tw3_scl_i),
    .sda_i   (tw3_sda_i),
    .match_q (tw3_m),
    .rd_q    (tw3_rd)
  );

  bps_tw_addr u_tw4 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .enable  (polling | (sel_if_q == `BPS_IF_TW4)),
    .scl_i   (tw4_scl_i),
    .sda_i   (tw4_sda_i),
    .match_q (tw4_m),
    .rd_q    (tw4_rd)
  );

  bps_ss_slave u_ss (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .enable     (polling | (sel_if_q == `BPS_IF_SS)),
    .sck_i      (ss_sck_i),
    .cs_n_i     (ss_cs_n_i),
    .mosi_i     (ss_mosi_i),
    .tx_byte    (ss_tx_byte),
    .miso_q     (ss_miso_q_w),
    .rx_byte_q  (ss_rx),
    .rx_valid_q (ss_v)
  );

  // ack waits for scl low after the 8th bit and holds through the 9th clock;
  // moving sda while scl is high would look like start or stop
  // enable low means driving sda low
  always @(posedge sys_clk) begin
    if (srst) begin
      tw3_scl_q      <= 1'b1;
      tw4_scl_q      <= 1'b1;
      tw3_pend_q     <= 1'b0;
      tw4_pend_q     <= 1'b0;
      tw3_ack_oe_n_q <= 1'b1;
      tw4_ack_oe_n_q <= 1'b1;
    end else begin
      tw3_scl_q <= tw3_scl_i;
      tw4_scl_q <= tw4_scl_i;
      if (tw3_m && !tw3_rd) begin
        tw3_pend_q <= 1'b1;
      end else if (fell(tw3_scl_q, tw3_scl_i)) begin
        tw3_pend_q     <= 1'b0;
        tw3_ack_oe_n_q <= ~tw3_pend_q;
      end
      if (tw4_m && !tw4_rd) begin
        tw4_pend_q <= 1'b1;
      end else if (fell(tw4_scl_q, tw4_scl_i)) begin
        tw4_pend_q     <= 1'b0;
        tw4_ack_oe_n_q <= ~tw4_pend_q;
      end
    end
  end

  // async sync-byte detector: fixed 57.6 kbaud divider, 8E1 frame
  // no rate detection: the host must use this one rate
  wire        a_mid  = (adiv_q == `BPS_ASYNC_HALF_CYC);
  wire        a_par  = ^ash_q[8:1];
  wire        a_sync = abusy_q && a_mid && (abit_q == 4'ha) && rx_q &&
                       (ash_q[8:1] == `BPS_SYNC_BYTE) && (a_par == ash_q[9]);

  always @(posedge sys_clk) begin
    if (srst) begin
      rx_q    <= 1'b1;
      abusy_q <= 1'b0;
      abit_q  <= 4'h0;
      ash_q   <= 10'h000;
      adiv_q  <= 12'h000;
    end else begin
      rx_q <= async_rx_i;
      if (!abusy_q) begin
        adiv_q <= 12'h000;
        abit_q <= 4'h0;
        if (!async_rx_i && rx_q && (polling || sel_if_q == `BPS_IF_ASYNC)) begin
          abusy_q <= 1'b1;
        end
      end else if (adiv_q == `BPS_ASYNC_BIT_CYC - 12'h001) begin
        adiv_q <= 12'h000;
      end else begin
        adiv_q <= adiv_q + 12'h001;
        if (a_mid) begin
          // lsb first: data then parity shift in from the top
          ash_q  <= {rx_q, ash_q[9:1]};
          abit_q <= abit_q + 4'h1;
          if (abit_q == 4'ha) begin
            abusy_q <= 1'b0;
          end
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      st_q               <= ST_POLL;
      sel_if_q           <= `BPS_IF_NONE;
      committed_q        <= 1'b0;
      port_clk_en_q      <= 7'h7e;
      port_irq_en_q      <= 7'h7e;
      usb_force_dev_q    <= 1'b0;
      sys_clk_src_q      <= `BPS_SRC_RC;
      pll_en_q           <= 1'b0;
      pll_mult_q         <= 8'h00;
      crystal_mhz_q      <= 8'h00;
      crystal_bad_q      <= 1'b0;
      win_q              <= 16'h0000;
      xcnt_q             <= 16'h0000;
      hs_periph_clk_en_q <= `BPS_HSPCE_BOOT;
      async_fmt_q        <= 2'h0;
      ss_miso_q          <= 1'b0;
      rx_byte_q          <= 8'h00;
      rx_byte_valid_q    <= 3'h0;
    end else begin
      ss_miso_q       <= ss_miso_q_w;
      rx_byte_valid_q <= {ss_v & (sel_if_q == `BPS_IF_SS), tw4_m, tw3_m};
      if (ss_v) begin
        rx_byte_q <= ss_rx;
      end
      case (st_q)
        ST_POLL: begin
          // first seen wins; fixed priority on a tie
          if (a_sync) begin
            sel_if_q    <= `BPS_IF_ASYNC;
            async_fmt_q <= 2'h1; // 8 data, even parity, 1 stop
            st_q        <= ST_RUN;
          end else if (tw3_m) begin
            sel_if_q <= `BPS_IF_TW3; // 400 kHz port
            st_q     <= ST_RUN;
          end else if (tw4_m) begin
            sel_if_q <= `BPS_IF_TW4; // 1 MHz port
            st_q     <= ST_RUN;
          end else if (ss_v) begin
            sel_if_q <= `BPS_IF_SS;
            st_q     <= ST_RUN;
          end else if (usb_cable_i || net_frame_i) begin
            sel_if_q <= usb_cable_i ? `BPS_IF_USB : `BPS_IF_NET;
            win_q    <= 16'h0000;
            xcnt_q   <= 16'h0000;
            st_q     <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          // timer counts crystal edges over an rc-timed window
          win_q <= win_q + 16'h0001;
          if (crystal_tick_i) begin
            xcnt_q <= xcnt_q + 16'h0001;
          end
          if (win_q == `BPS_MEAS_WIN_CYC - 16'h0001) begin
            crystal_mhz_q <= to_mhz(xcnt_q);
            // out of range crystal is refused
            if (to_mhz(xcnt_q) < `BPS_XTAL_MIN_MHZ || to_mhz(xcnt_q) > `BPS_XTAL_MAX_MHZ) begin
              crystal_bad_q <= 1'b1;
              st_q          <= ST_FAIL;
            end else begin
              pll_en_q   <= 1'b1;
              // multiplier gives 60 MHz only for crystals whose MHz value divides 60
              pll_mult_q <= `BPS_SYS_TARGET_MHZ / to_mhz(xcnt_q);
              st_q       <= ST_LOCK;
            end
          end
        end
        ST_LOCK: begin
          sys_clk_src_q <= `BPS_SRC_PLL; // leave rc clock after selection
          st_q          <= ST_RUN;
        end
        ST_RUN: begin
          committed_q   <= 1'b1;
          // gate all but the chosen port
          port_clk_en_q <= port_bit(sel_if_q);
          port_irq_en_q <= port_bit(sel_if_q);
          if (sel_if_q == `BPS_IF_USB) begin
            usb_force_dev_q <= 1'b1; // no role negotiation
          end
          if (sel_if_q == `BPS_IF_ASYNC || sel_if_q == `BPS_IF_TW3 ||
              sel_if_q == `BPS_IF_TW4) begin
            sys_clk_src_q <= `BPS_SRC_RC;
          end
          if (go_cmd_i) begin
            hs_periph_clk_en_q <= `BPS_HSPCE_CLEAR; // user code re-enables memory
          end
        end
        ST_FAIL: begin
          // stays here; a system reset is the only way out
          st_q <= ST_FAIL;
        end
        default: begin
          st_q <= ST_POLL;
        end
      endcase
    end
  end
endmodule

// file: hdl/bps_map.vh
/*
 boot port selection constants: addresses, frame widths, timing counts, port and clock source codes.
 assumes a 25 MHz sys_clk; included by the bps design files.
*/
`ifndef BPS_MAP_VH
`define BPS_MAP_VH

`define BPS_SLAVE_ADDR       7'h46
`define BPS_FRAME_BITS       4'h8
`define BPS_SYNC_BYTE        8'h7f
`define BPS_CLK_HZ           25000000
`define BPS_TW3_MAX_HZ       400000
`define BPS_TW4_MAX_HZ       1000000
`define BPS_SS_MAX_HZ        8000000
`define BPS_XTAL_MIN_MHZ     8'h04
`define BPS_XTAL_MAX_MHZ     8'h1a
`define BPS_SYS_TARGET_MHZ   8'h3c
`define BPS_MEAS_WIN_CYC     16'h61a8
`define BPS_TICKS_PER_MHZ    16'h03e8
`define BPS_TICKS_ROUND      16'h01f4
`define BPS_ASYNC_HALF_CYC   12'h0d9
`define BPS_ASYNC_BIT_CYC    12'h1b2
`define BPS_HSPCE_CLEAR      32'h00000000
`define BPS_HSPCE_BOOT       32'h00000001

`define BPS_SRC_RC           2'h0
`define BPS_SRC_PLL          2'h1

`define BPS_IF_NONE          3'h0
`define BPS_IF_ASYNC         3'h1
`define BPS_IF_TW3           3'h2
`define BPS_IF_TW4           3'h3
`define BPS_IF_SS            3'h4
`define BPS_IF_USB           3'h5
`define BPS_IF_NET           3'h6

`endif

// file: hdl/bps_ss_slave.v
/*
 synchronous serial slave, mode 0, 8-bit msb first, full duplex.
 assumes sck at most 8 MHz so each edge is seen by the 25 MHz sampler.
*/
`timescale 1ns/10ps
`include "bps_map.vh"

module bps_ss_slave (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       enable,
  input  wire       sck_i,
  input  wire       cs_n_i,
  input  wire       mosi_i,
  input  wire [7:0] tx_byte,
  output reg        miso_q,
  output reg  [7:0] rx_byte_q,
  output reg        rx_valid_q
);
  reg       sck_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;

  wire sel  = enable & ~cs_n_i;
  wire rise = sck_i & ~sck_q;
  wire fall = ~sck_i & sck_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      sck_q      <= 1'b0;
      cnt_q      <= 3'h0;
      sh_q       <= 8'h00;
      tx_q       <= 8'h00;
      miso_q     <= 1'b0;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      sck_q      <= sck_i;
      rx_valid_q <= 1'b0;
      if (!sel) begin
        // hardware chip select restarts the frame
        cnt_q  <= 3'h0;
        tx_q   <= tx_byte;
        miso_q <= tx_byte[7];
      end else if (rise) begin
        // sample on rising edge, idle low
        sh_q  <= {sh_q[6:0], mosi_i};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          rx_byte_q  <= {sh_q[6:0], mosi_i};
          rx_valid_q <= 1'b1;
          tx_q       <= tx_byte;
        end
      end else if (fall) begin
        if (cnt_q == 3'h0) begin
          miso_q <= tx_q[7];
        end else begin
          miso_q <= tx_q[3'h7 - cnt_q]; // msb first
        end
      end
    end
  end
endmodule

// file: hdl/bps_tw_addr.v
/*
 two-wire slave address matcher: samples the first byte after a start
 condition and pulses on a match with the fixed boot address.
 assumes scl/sda already filtered and synchronous to sys_clk.
*/
`timescale 1ns/10ps
`include "bps_map.vh"

module bps_tw_addr (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       enable,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        match_q,
  output reg        rd_q
);
  reg       scl_q;
  reg       sda_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg       act_q;

  wire start = scl_i & scl_q & sda_q & ~sda_i;
  wire rise  = scl_i & ~scl_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      act_q   <= 1'b0;
      match_q <= 1'b0;
      rd_q    <= 1'b0;
    end else begin
      scl_q   <= scl_i;
      sda_q   <= sda_i;
      match_q <= 1'b0;
      if (!enable) begin
        act_q <= 1'b0;
      end else if (start) begin
        act_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (act_q && rise) begin
        sh_q  <= {sh_q[6:0], sda_i};
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == `BPS_FRAME_BITS - 4'h1) begin
          act_q <= 1'b0;
          // last bit picks write or read
          if (sh_q[6:0] == `BPS_SLAVE_ADDR) begin
            match_q <= 1'b1;
            rd_q    <= sda_i;
          end
        end
      end
    end
  end
endmodule
